// file: pkg/smw_params.svh
/*
 * Constants for the stop mode and wake control block: widths, delays and reset levels.
 * Assumes it is included by bare name from files that use these macros.
 */
// Notes on behaviour
// - Stop enters lowest power unless stop disabled.
// - Stop halts every clock and the oscillator.
// - Stop ends on reset, nonmaskable, unmasked irq.
// - Nonmaskable pin wakes stop regardless of its mask.
// - Nonmaskable wake, mask clear: stack then service.
// - Nonmaskable wake, mask set: resume next instruction.
// - Reset ends stop, then fetch reset vector.
// - Internal oscillator: wait 4064 cycles after wake.
// - Delay select zero shortens delay to four.
// - Single chip wait/stop: port and strobe hold.
// - Expanded wait: port C shows stack minus eight.
// - Expanded: port B shows high address always; the code holds it at 8'h00 while reset is low.
// - Expanded reset: port C multiplexes address, data; the code holds it at 8'h00 while reset is low.
// - Wait/stop: mode A pin open drain, one.
// - Nonmaskable mask: hardware sets, instructions clear.
// - Wait stacks, halts, exits on interrupt or reset.
`ifndef SMW_PARAMS_SVH
`define SMW_PARAMS_SVH

// Stabilization delay in clock cycles for the internal oscillator.
`define SMW_STAB_LONG    12'hFE0
// Short delay in cycles for a stable external clock.
`define SMW_STAB_SHORT   12'h004
// Cycle the sequencer needs to see done; taken off the counter load.
`define SMW_DONE_LAG     12'h001
// Width of the stabilization counter.
`define SMW_CNT_W        12
// Offset subtracted from the stack pointer shown during wait.
`define SMW_SP_OFFSET    16'h0_008
// Level the strobe pin takes in expanded mode outside single chip hold.
`define SMW_STRB_EXP     1'h1
// Reset level of port outputs.
`define SMW_PORT_RST     8'h00
`define SMW_PA_RST       4'h0
// Level of the nonmaskable mask flag after reset.
`define SMW_XMASK_RST    1'h1
// Driven level of the mode A pin during wait and stop.
`define SMW_MODA_DRIVE   1'h1

`endif

// file: pkg/smw_pkg.sv
/*
 * Types of the stop mode and wake control block.
 * Assumes smw_params.svh is available on the include path.
 */
`include "smw_params.svh"
package smw_pkg;

	// Sequencer states.
	typedef enum logic [2:0] {
		SMW_BOOT,
		SMW_RUN,
		SMW_WAIT,
		SMW_STOP,
		SMW_STAB
	} smw_state_e;

	// What woke the core, decides the action once the clock is stable.
	typedef enum logic [1:0] {
		SMW_WK_XSVC,
		SMW_WK_XRESUME,
		SMW_WK_IRQ
	} smw_cause_e;

	// Counter type for the stabilization delay.
	typedef logic [`SMW_CNT_W-1:0] smw_cnt_t;

endpackage : smw_pkg

// file: pkg/smw_if.sv
/*
 * Carrier between the sequencer and its stabilization counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface smw_if;
	import smw_pkg::*;

	logic     start;    // One-cycle pulse that loads the counter.
	smw_cnt_t length;   // Cycles to wait, sampled with start.
	logic     done;     // One-cycle pulse when the wait ends.
	logic     busy;     // High while counting.

	modport seq (output start, output length, input done, input busy);
	modport ctr (input start, input length, output done, output busy);
endinterface : smw_if
`default_nettype wire

// file: src/smw_delay.sv
/*
 * Stabilization delay counter for the stop exit sequence.
 * Assumes start is a one-cycle pulse and length is at least one.
 */
`timescale 1ns/1ps
`default_nettype none
module smw_delay
	import smw_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	smw_if.ctr        dly
);

	// Whole state of the counter.
	typedef struct packed {
		smw_cnt_t cnt;
		logic     done;
	} smw_dly_s;

	smw_dly_s cur;       // Registered state.
	smw_dly_s next_cur;  // Next state.

	// The done pulse lands exactly length cycles after start.
	always_comb begin
		next_cur      = cur;
		next_cur.done = 1'b0;
		if (dly.start) begin
			next_cur.cnt = dly.length;
		end else if (cur.cnt != '0) begin
			next_cur.cnt = cur.cnt - 1'b1;
			// The last count raises done for one cycle.
			if (cur.cnt == smw_cnt_t'(1)) begin
				next_cur.done = 1'b1;
			end
		end
	end

	// Register the state.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign dly.done = cur.done;
	assign dly.busy = (cur.cnt != '0);

endmodule : smw_delay
`default_nettype wire

// file: src/smw_top.sv
/*
 * Stop and wait low-power control: wake decision, oscillator restart delay,
 * nonmaskable mask flag and pin states during reset, wait and stop.
 * Assumes instruction strobes come from the core as one-cycle pulses on clk_i,
 * and that pins are synchronous to clk_i.  The block itself stays clocked:
 * in silicon this wake logic sits on an always-on path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "smw_params.svh"
module smw_top
	import smw_pkg::*;
(
	input  wire logic        clk_i,                      // Core clock.
	input  wire logic        arst_n_i,                   // External reset, low.
	input  wire logic        stop_instr_i,               // Stop instruction executed.
	input  wire logic        wait_instruction_i,         // Wait instruction executed.
	input  wire logic        stop_disable_i,             // Stop-disable flag.
	input  wire logic        irq_mask_i,                 // Maskable mask flag.
	input  wire logic        nonmaskable_irq_pin_ack_i,                 // Nonmaskable acknowledge.
	input  wire logic        return_from_interrupt_instr_i, // Clears mask.
	input  wire logic        flag_transfer_instr_i,      // Flag transfer clear.
	input  wire logic        flag_transfer_x_i,          // Mask value being transferred.
	input  wire logic        nonmaskable_irq_pin_n_i,    // Nonmaskable pin, low.
	input  wire logic        irq_pin_n_i,                // Maskable pin, low.
	input  wire logic        stop_exit_delay_select_i,   // One: long delay.
	input  wire logic        expanded_mode_i,            // Expanded operation.
	input  wire logic        addr_phase_i,               // Address time of a bus cycle.
	input  wire logic [15:0] addr_i,                     // Core address.
	input  wire logic [7:0]  data_i,                     // Core data.
	input  wire logic [15:0] stack_ptr_i,                // Stack pointer.
	input  wire logic [3:0]  port_a_value_i,             // Port A outputs wanted.
	input  wire logic [7:0]  port_b_value_i,             // Port B single chip value.
	input  wire logic [7:0]  port_c_value_i,             // Port C single chip value.
	input  wire logic        strobe_value_i,             // Strobe wanted.
	output logic             clock_run_o,                // Internal clocks enabled.
	output logic             osc_enable_o,               // Oscillator enabled.
	output logic             cpu_run_o,                  // Core may execute.
	output logic             in_stop_o,                  // Stop mode.
	output logic             in_wait_o,                  // Wait mode.
	output logic             stack_state_o,              // Stack state pulse.
	output logic             service_nonmaskable_irq_pin_o,             // Service nonmaskable pulse.
	output logic             service_irq_o,              // Service maskable pulse.
	output logic             resume_next_o,              // Resume after stop pulse.
	output logic             reset_vector_o,             // Fetch reset vector pulse.
	output logic             x_mask_o,                   // Nonmaskable mask flag.
	output logic [3:0]       port_a_outputs_o,           // Port A pins.
	output logic [7:0]       port_b_pins_o,              // Port B pins.
	output logic [7:0]       port_c_pins_o,              // Port C pins.
	output logic             strobe_or_rw_pin_o,         // Strobe pin.
	output logic             mode_a_fetch_flag_pin_o,    // Mode A pin level.
	output logic             mode_a_fetch_flag_pin_oe_o  // Mode A pin drive.
);

	// Whole registered state; every output is a field of it, except in_stop_o and in_wait_o, which are decoded from st.
	typedef struct packed {
		smw_state_e  st;
		smw_cause_e  cause;
		logic        xmask;
		logic [15:0] sp_cap;
		logic        clk_run;
		logic        osc_en;
		logic        cpu_run;
		logic        stack;
		logic        svc_x;
		logic        svc_i;
		logic        resume;
		logic        rvec;
		logic [3:0]  pa;
		logic [7:0]  pb;
		logic [7:0]  pc;
		logic        strb;
		logic        moda;
		logic        moda_oe;
	} smw_state_s;

	smw_state_s cur;       // Registered state.
	smw_state_s next_cur;  // Next state.

	smw_if dly ();         // Link to the stabilization counter.

	// Counter for the oscillator restart delay.
	smw_delay u_delay (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.dly      (dly)
	);

	logic nonmaskable_irq_pin_act;   // Nonmaskable pin asserted.
	logic irq_ok;     // Maskable pin asserted and unmasked.

	// Decode of the wake sources.
	always_comb begin
		nonmaskable_irq_pin_act = !nonmaskable_irq_pin_n_i;
		irq_ok   = !irq_pin_n_i && !irq_mask_i;
	end

	// Sequencer, mask flag and pin multiplexing in one next-state process.
	always_comb begin
		next_cur        = cur;
		next_cur.stack  = 1'b0;
		next_cur.svc_x  = 1'b0;
		next_cur.svc_i  = 1'b0;
		next_cur.resume = 1'b0;
		next_cur.rvec   = 1'b0;
		dly.start       = 1'b0;
		// short delay select
		// The sequencer reacts to done one cycle after the counter raises it, so
		// the load is one short; the oscillator then runs exactly the full delay.
		dly.length      = (stop_exit_delay_select_i ? `SMW_STAB_LONG : `SMW_STAB_SHORT)
			- `SMW_DONE_LAG;

		unique case (cur.st)
			SMW_BOOT: begin
				next_cur.rvec    = 1'b1;
				next_cur.cpu_run = 1'b1;
				next_cur.st      = SMW_RUN;
			end
			SMW_RUN: begin
				if (stop_instr_i && !stop_disable_i) begin
					next_cur.st      = SMW_STOP;
					next_cur.clk_run = 1'b0;
					next_cur.osc_en  = 1'b0;
					next_cur.cpu_run = 1'b0;
				end else if (wait_instruction_i) begin
					next_cur.st      = SMW_WAIT;
					next_cur.stack   = 1'b1;
					next_cur.cpu_run = 1'b0;
					next_cur.sp_cap  = stack_ptr_i;
				end
				// A disabled stop simply falls through as a no-operation.
			end
			SMW_WAIT: begin
				if (nonmaskable_irq_pin_act && !cur.xmask) begin
					next_cur.svc_x   = 1'b1;
					next_cur.cpu_run = 1'b1;
					next_cur.st      = SMW_RUN;
				end else if (irq_ok) begin
					next_cur.svc_i   = 1'b1;
					next_cur.cpu_run = 1'b1;
					next_cur.st      = SMW_RUN;
				end
			end
			SMW_STOP: begin
				if (nonmaskable_irq_pin_act || irq_ok) begin
					// The nonmaskable pin wins when both arrive together.
					if (nonmaskable_irq_pin_act) begin
						next_cur.cause = cur.xmask ? SMW_WK_XRESUME : SMW_WK_XSVC;
					end else begin
						next_cur.cause = SMW_WK_IRQ;
					end
					next_cur.osc_en = 1'b1;
					next_cur.st     = SMW_STAB;
					dly.start       = 1'b1;
				end
			end
			SMW_STAB: begin
				// The core stays halted until the oscillator has settled.
				if (dly.done) begin
					next_cur.clk_run = 1'b1;
					next_cur.cpu_run = 1'b1;
					next_cur.st      = SMW_RUN;
					unique case (cur.cause)
						SMW_WK_XSVC: begin
							next_cur.stack = 1'b1;
							next_cur.svc_x = 1'b1;
						end
						SMW_WK_XRESUME: begin
							next_cur.resume = 1'b1;
						end
						SMW_WK_IRQ: begin
							next_cur.stack = 1'b1;
							next_cur.svc_i = 1'b1;
						end
					endcase
				end
			end
		endcase

		// mask set by hardware, set wins over clear
		if (nonmaskable_irq_pin_ack_i || next_cur.svc_x) begin
			next_cur.xmask = 1'b1;
		end else if (return_from_interrupt_instr_i) begin
			next_cur.xmask = 1'b0;
		end else if (flag_transfer_instr_i && !flag_transfer_x_i) begin
			next_cur.xmask = 1'b0;
		end

		// Pin states follow the mode entered in this cycle.
		if (expanded_mode_i) begin
			next_cur.pb   = addr_i[15:8];
			next_cur.strb = `SMW_STRB_EXP;
			if (next_cur.st == SMW_WAIT) begin
				next_cur.pc = addr_phase_i ? 8'((next_cur.sp_cap - `SMW_SP_OFFSET))
					: data_i;
			end else if (next_cur.st == SMW_RUN) begin
				next_cur.pc = addr_phase_i ? addr_i[7:0] : data_i;
			end else begin
				next_cur.pc = addr_i[7:0];
			end
			if (next_cur.st == SMW_RUN) begin
				next_cur.pa = port_a_value_i;
			end
		end else if (next_cur.st == SMW_RUN) begin
			next_cur.pa   = port_a_value_i;
			next_cur.pb   = port_b_value_i;
			next_cur.pc   = port_c_value_i;
			next_cur.strb = strobe_value_i;
		end
		// single chip hold: nothing above changes pins while held.

		// mode A pin open drain one
		next_cur.moda_oe = (next_cur.st != SMW_RUN) && (next_cur.st != SMW_BOOT);
		next_cur.moda    = next_cur.moda_oe ? `SMW_MODA_DRIVE : 1'b0;
	end

	// Register the state; reset holds the core off and masks the pin.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cur         <= '0;
			cur.st      <= SMW_BOOT;
			cur.cause   <= SMW_WK_XSVC;
			cur.xmask   <= `SMW_XMASK_RST;
			cur.clk_run <= 1'b1;
			cur.osc_en  <= 1'b1;
			cur.pa      <= `SMW_PA_RST;
			cur.pb      <= `SMW_PORT_RST;
			cur.pc      <= `SMW_PORT_RST;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs straight from flip-flops; in_stop_o and in_wait_o are decoded from the registered state.
	assign clock_run_o                = cur.clk_run;
	assign osc_enable_o               = cur.osc_en;
	assign cpu_run_o                  = cur.cpu_run;
	assign in_stop_o                  = (cur.st == SMW_STOP) || (cur.st == SMW_STAB);
	assign in_wait_o                  = (cur.st == SMW_WAIT);
	assign stack_state_o              = cur.stack;
	assign service_nonmaskable_irq_pin_o             = cur.svc_x;
	assign service_irq_o              = cur.svc_i;
	assign resume_next_o              = cur.resume;
	assign reset_vector_o             = cur.rvec;
	assign x_mask_o                   = cur.xmask;
	assign port_a_outputs_o           = cur.pa;
	assign port_b_pins_o              = cur.pb;
	assign port_c_pins_o              = cur.pc;
	assign strobe_or_rw_pin_o         = cur.strb;
	assign mode_a_fetch_flag_pin_o    = cur.moda;
	assign mode_a_fetch_flag_pin_oe_o = cur.moda_oe;

endmodule : smw_top
`default_nettype wire

// file: dv/smw_pin_model.sv
/*
 * Far-side model of the two wake pins, nonmaskable and maskable interrupt.
 * Assumes the bench changes the request levels at the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module smw_pin_model (
	input  wire logic x_req_i,                 // Pull the nonmaskable pin low.
	input  wire logic i_req_i,                 // Pull the maskable pin low.
	output logic      nonmaskable_irq_pin_n_o, // Nonmaskable pin level.
	output logic      irq_pin_n_o              // Maskable pin level.
);
	// Both pins have pull-ups, so a released pin reads high and never keeps a stale low.
	assign nonmaskable_irq_pin_n_o = ~x_req_i;
	assign irq_pin_n_o             = ~i_req_i;
endmodule : smw_pin_model
`default_nettype wire

// file: dv/smw_top_assertions.sv
/*
 * Timing checks on the ports of smw_top.
 * Assumes one clock domain and the asynchronous active low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module smw_top_assertions (
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic        stop_instr_i,
	input wire logic        wait_instruction_i,
	input wire logic        stop_disable_i,
	input wire logic        irq_mask_i,
	input wire logic        return_from_interrupt_instr_i,
	input wire logic        flag_transfer_instr_i,
	input wire logic        flag_transfer_x_i,
	input wire logic        nonmaskable_irq_pin_n_i,
	input wire logic        irq_pin_n_i,
	input wire logic        stop_exit_delay_select_i,
	input wire logic        expanded_mode_i,
	input wire logic        addr_phase_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] stack_ptr_i,
	input wire logic        clock_run_o,
	input wire logic        osc_enable_o,
	input wire logic        cpu_run_o,
	input wire logic        in_stop_o,
	input wire logic        in_wait_o,
	input wire logic        stack_state_o,
	input wire logic        service_nonmaskable_irq_pin_o,
	input wire logic        service_irq_o,
	input wire logic        resume_next_o,
	input wire logic        reset_vector_o,
	input wire logic        x_mask_o,
	input wire logic [3:0]  port_a_outputs_o,
	input wire logic [7:0]  port_b_pins_o,
	input wire logic [7:0]  port_c_pins_o,
	input wire logic        strobe_or_rw_pin_o,
	input wire logic        mode_a_fetch_flag_pin_o,
	input wire logic        mode_a_fetch_flag_pin_oe_o
);
	logic [12:0] cnt;    // Restart delay cycles seen so far.
	logic [15:0] sp_cap; // Stack pointer at wait entry, less eight.

	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	// Counts while the oscillator runs again but the core is still held.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt    <= 13'h0000;
			sp_cap <= 16'h0000;
		end else begin
			cnt <= (in_stop_o && osc_enable_o && !cpu_run_o) ? cnt + 13'h0001 : 13'h0000;
			if (wait_instruction_i && cpu_run_o) begin
				sp_cap <= stack_ptr_i - 16'h0008;
			end
		end
	end

	AST_STOP_IGNORED: assert property (cpu_run_o && stop_instr_i && stop_disable_i
		|=> !in_stop_o && cpu_run_o) else $error("stop taken while disabled");
	AST_STOP_ENTER: assert property (cpu_run_o && stop_instr_i && !stop_disable_i
		|=> in_stop_o && !clock_run_o && !osc_enable_o && !cpu_run_o) else $error("no stop");
	AST_STOP_ASLEEP: assert property (in_stop_o && !osc_enable_o && nonmaskable_irq_pin_n_i
		&& (irq_pin_n_i || irq_mask_i) |=> !osc_enable_o) else $error("spurious wake");
	AST_NONMASKABLE_IRQ_PIN_WAKE: assert property (in_stop_o && !osc_enable_o && !nonmaskable_irq_pin_n_i
		|=> osc_enable_o) else $error("nonmaskable pin did not wake");
	AST_WAKE_DELAY: assert property ($rose(cpu_run_o) && $past(in_stop_o)
		|-> cnt == (stop_exit_delay_select_i ? 13'h0FE0 : 13'h0004))
		else $error("restart delay length wrong");
	AST_NONMASKABLE_IRQ_PIN_SERVICE: assert property (service_nonmaskable_irq_pin_o
		|-> (stack_state_o || $past(in_wait_o)) && x_mask_o && !resume_next_o)
		else $error("bad service");
	AST_RESUME: assert property (resume_next_o
		|-> !stack_state_o && !service_nonmaskable_irq_pin_o && !service_irq_o) else $error("bad resume");
	AST_RESET_VECTOR: assert property ($rose(arst_n_i)
		|=> reset_vector_o && cpu_run_o) else $error("no reset vector fetch");
	AST_PIN_HOLD: assert property (!expanded_mode_i && (in_wait_o || in_stop_o)
		&& $past(in_wait_o || in_stop_o) |-> $stable({port_a_outputs_o, port_b_pins_o,
		port_c_pins_o, strobe_or_rw_pin_o})) else $error("pins moved in low power");
	AST_PORT_B_HIGH: assert property ($past(expanded_mode_i) && $past(arst_n_i)
		|-> port_b_pins_o == $past(addr_i[15:8]) && strobe_or_rw_pin_o)
		else $error("port b not high address");
	AST_SP_MINUS_8: assert property (in_wait_o && addr_phase_i && expanded_mode_i
		|=> !in_wait_o || port_c_pins_o == sp_cap[7:0]) else $error("port c not stack less eight");
	AST_MODE_A: assert property (in_wait_o || in_stop_o
		|-> mode_a_fetch_flag_pin_oe_o && mode_a_fetch_flag_pin_o) else $error("mode a pin");
	AST_WAIT_EXIT: assert property (in_wait_o && nonmaskable_irq_pin_n_i && !irq_pin_n_i
		&& !irq_mask_i |=> service_irq_o && cpu_run_o && !in_wait_o) else $error("wait");
	AST_XMASK_CLEAR: assert property ($fell(x_mask_o) |-> $past(return_from_interrupt_instr_i
		|| (flag_transfer_instr_i && !flag_transfer_x_i))) else $error("mask cleared");
endmodule : smw_top_assertions

bind smw_top smw_top_assertions smw_top_assertions_i (.*);
`default_nettype wire

// file: dv/smw_top_tb_top.sv
/*
 * Self-checking bench for smw_top: stop, wait, wake, mask and pin sequences.
 * Assumes the bound checker and the wake pin model.
 */
`timescale 1ns/1ps
`default_nettype none
module smw_top_tb_top;
	import smw_pkg::*;
	logic clk_i = 0, arst_n_i = 0, stop_instr_i = 0, wait_instruction_i = 0, nonmaskable_irq_pin_ack_i = 0;
	logic return_from_interrupt_instr_i = 0, flag_transfer_instr_i = 0, flag_transfer_x_i = 1;
	logic stop_disable_i = 0, irq_mask_i = 1, stop_exit_delay_select_i = 0, expanded_mode_i = 0;
	logic addr_phase_i = 0, x_req = 0, i_req = 0;
	logic [15:0] stack_ptr_i = 16'h0000;
	logic [27:0] cnt = 28'h000_0000; // Moving source so held pins are really tested.
	wire logic nonmaskable_irq_pin_n_i, irq_pin_n_i;
	wire logic [15:0] addr_i = cnt[27:12];
	wire logic [7:0] data_i = cnt[7:0], port_b_value_i = cnt[11:4], port_c_value_i = cnt[19:12];
	wire logic [3:0] port_a_value_i = cnt[3:0];
	wire logic strobe_value_i = cnt[0];
	logic clock_run_o, osc_enable_o, cpu_run_o, in_stop_o, in_wait_o, stack_state_o;
	logic service_nonmaskable_irq_pin_o, service_irq_o, resume_next_o, reset_vector_o, x_mask_o;
	logic strobe_or_rw_pin_o, mode_a_fetch_flag_pin_o, mode_a_fetch_flag_pin_oe_o;
	logic [3:0] port_a_outputs_o;
	logic [7:0] port_b_pins_o, port_c_pins_o;
	int n_errors = 0, checks_done = 0;

	smw_top smw_top_i (.*);
	smw_pin_model smw_pin_model_i (.x_req_i(x_req), .i_req_i(i_req),
		.nonmaskable_irq_pin_n_o(nonmaskable_irq_pin_n_i), .irq_pin_n_o(irq_pin_n_i));

	always #5 clk_i = ~clk_i;
	always @(negedge clk_i) cnt <= cnt + 28'h000_0001;

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One-cycle core strobes: stop, wait, return, flag transfer, acknowledge.
	task automatic strobe(input logic [4:0] s);
		{stop_instr_i, wait_instruction_i, return_from_interrupt_instr_i,
			flag_transfer_instr_i, nonmaskable_irq_pin_ack_i} = s;
		@(negedge clk_i);
		{stop_instr_i, wait_instruction_i, return_from_interrupt_instr_i,
			flag_transfer_instr_i, nonmaskable_irq_pin_ack_i} = 5'h00;
	endtask : strobe

	// Stop with a masked irq held low, then wake by the chosen pin and time the restart.
	task automatic stop_wake(input logic x, input logic i, input logic sel, input int len,
		input logic [2:0] pul);
		int n;
		n = 0;
		stop_exit_delay_select_i = sel;
		i_req = 1;
		// Let the release of the previous strobe pass a clock edge first.
		@(negedge clk_i);
		strobe(5'h10);
		repeat (3) @(negedge clk_i);
		chk("asleep", 16'h0001, in_stop_o & ~osc_enable_o & ~clock_run_o);
		irq_mask_i = ~i;
		x_req = x;
		i_req = i;
		while (cpu_run_o !== 1'h1 && n < 5000) begin
			@(negedge clk_i);
			n++;
		end
		chk("wake cycles", 16'(len + 1), 16'(n));
		chk("wake pulses", 16'(pul), {service_nonmaskable_irq_pin_o, service_irq_o, resume_next_o});
		x_req = 0;
		i_req = 0;
		irq_mask_i = 1;
		@(negedge clk_i);
	endtask : stop_wake

	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim

	// Watchdog well beyond the longest restart delay.
	initial begin
		#100000;
		n_errors++;
		end_sim;
	end

	initial begin
		repeat (4) @(negedge clk_i);
		arst_n_i = 1;
		@(negedge clk_i);
		chk("reset vector", 16'h0001, reset_vector_o);
		@(negedge clk_i);
		chk("mask after reset", 16'h0001, x_mask_o);
		stop_disable_i = 1;
		strobe(5'h10);
		@(negedge clk_i);
		chk("disabled stop", 16'h0000, in_stop_o);
		stop_disable_i = 0;
		stop_wake(1, 0, 0, 4, 3'h1);
		strobe(5'h04);
		chk("mask after return", 16'h0000, x_mask_o);
		stop_wake(1, 0, 0, 4, 3'h4);
		chk("mask after service", 16'h0001, x_mask_o);
		flag_transfer_x_i = 0;
		strobe(5'h02);
		flag_transfer_x_i = 1;
		@(negedge clk_i);
		strobe(5'h02);
		chk("mask after transfer", 16'h0000, x_mask_o);
		stop_wake(0, 1, 1, 4064, 3'h2);
		strobe(5'h01);
		chk("mask after acknowledge", 16'h0001, x_mask_o);
		expanded_mode_i = 1;
		stack_ptr_i = 16'h1234;
		@(negedge clk_i);
		strobe(5'h08);
		chk("wait entry", 16'h0003, {in_wait_o, stack_state_o});
		stack_ptr_i = 16'h0000;
		addr_phase_i = 1;
		i_req = 1;
		@(negedge clk_i);
		chk("port c in wait", 16'h002C, port_c_pins_o);
		chk("mode a pin", 16'h0003, {mode_a_fetch_flag_pin_oe_o, mode_a_fetch_flag_pin_o});
		irq_mask_i = 0;
		@(negedge clk_i);
		chk("wait exit", 16'h0002, {service_irq_o, in_wait_o});
		i_req = 0;
		irq_mask_i = 1;
		@(negedge clk_i);
		chk("port c address", {8'h00, addr_i[7:0]}, {8'h00, port_c_pins_o});
		addr_phase_i = 0;
		@(negedge clk_i);
		chk("port c data", {8'h00, data_i}, {8'h00, port_c_pins_o});
		chk("port b address", {8'h00, addr_i[15:8]}, {8'h00, port_b_pins_o});
		@(negedge clk_i);
		end_sim;
	end
endmodule : smw_top_tb_top
`default_nettype wire
